// File: rtl/acs_clock_select.sv
// Interface clock source selection and sample rate reference logic
`timescale 1ns/100ps
`include "acs_regs.svh"


module acs_clock_select (
  // Clock and reset
  input  wire logic               core_clk_i,
  input  wire logic               reset_i,
  // Control port
  input  wire logic               wr_i,
  input  wire logic [6:0]         addr_i,
  input  wire logic [8:0]         wdata_i,
  output logic      [8:0]         rdata_o,
  // Clock and frame pins: main, adc pin, pll a, pll b, prx, ptx, sec, secrx, sub
  input  wire logic [8:0]         pin_i,
  // Device status
  input  wire logic               primary_rx_master_i,
  // Clock choices
  output acs_pkg::acs_src_t       dac1_source_field_o,
  output acs_pkg::acs_src_t       adc_src_o,
  output acs_pkg::acs_src_t       spdif_tx_src_o,
  output acs_pkg::acs_src_t       spdif_rx_src_o,
  output acs_pkg::acs_src_t       prx_gen_src_o,
  output logic                    prx_gen_en_o,
  // DAC power and routing
  output logic                    dac234_power_down_o,
  output logic                    dac234_from_primary_o,
  // Ratios
  output acs_pkg::acs_ratio_t     dac_ratio_o,
  output acs_pkg::acs_ratio_t     adc_ratio_o,
  output acs_pkg::acs_ratio_t     tx_ratio_o
);

  // ==========================================================
  // Register storage
  logic [8:0] clk_sel;
  logic [8:0] prx_ms;
  logic [8:0] dac1_src;
  logic [8:0] ptx_src;
  logic [8:0] stx_src;
  logic [8:0] dac_mode;
  logic [8:0] adc_ctl;
  logic [8:0] sptx_src;

  // Write decode; unmapped writes are dropped
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      clk_sel  <= `ACS_RST_CLKSEL;
      prx_ms   <= `ACS_RST_PRXMS;
      dac1_src <= `ACS_RST_DAC1SRC;
      ptx_src  <= `ACS_RST_PTXSRC;
      stx_src  <= `ACS_RST_STXSRC;
      dac_mode <= `ACS_RST_DACMODE;
      adc_ctl  <= `ACS_RST_ADCCTL;
      sptx_src <= `ACS_RST_SPTXSRC;
    end else if (wr_i) begin
      unique case (addr_i)
        `ACS_A_CLKSEL:  clk_sel  <= wdata_i;
        `ACS_A_PRXMS:   prx_ms   <= wdata_i;
        `ACS_A_DAC1SRC: dac1_src <= wdata_i;
        `ACS_A_PTXSRC:  ptx_src  <= wdata_i;
        `ACS_A_STXSRC:  stx_src  <= wdata_i;
        `ACS_A_DACMODE: dac_mode <= wdata_i;
        `ACS_A_ADCCTL:  adc_ctl  <= wdata_i;
        `ACS_A_SPTXSRC: sptx_src <= wdata_i;
        default: ;
      endcase
    end
  end

  // Readback shows fields as written, never the applied choice
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_o <= 9'h000;
    end else begin
      unique case (addr_i)
        `ACS_A_CLKSEL:  rdata_o <= clk_sel;
        `ACS_A_PRXMS:   rdata_o <= prx_ms;
        `ACS_A_DAC1SRC: rdata_o <= dac1_src;
        `ACS_A_PTXSRC:  rdata_o <= ptx_src;
        `ACS_A_STXSRC:  rdata_o <= stx_src;
        `ACS_A_DACMODE: rdata_o <= dac_mode;
        `ACS_A_ADCCTL:  rdata_o <= adc_ctl;
        `ACS_A_SPTXSRC: rdata_o <= sptx_src;
        default:        rdata_o <= 9'h000;
      endcase
    end
  end

  // ==========================================================
  // Field views
  logic       manual;
  logic       rx2dac;
  logic [1:0] dac1_route;
  logic [1:0] ptx_route;
  logic [1:0] stx_route;
  logic [1:0] tx_route;
  logic [2:0] adc_field;

  assign manual     = clk_sel[`ACS_B_MANUAL];
  assign rx2dac     = dac_mode[`ACS_B_RX2DAC];
  assign dac1_route = dac1_src[`ACS_F_ROUTE];
  assign ptx_route  = ptx_src[`ACS_F_ROUTE];
  assign stx_route  = stx_src[`ACS_F_ROUTE];
  assign tx_route   = sptx_src[`ACS_F_TXDATA];
  assign adc_field  = adc_ctl[`ACS_F_ADC_RATIO_FIELD];

  // ==========================================================
  // Pin synchronisers and edge pulses
  logic [8:0] sync1;
  logic [8:0] sync2;
  logic [8:0] sync3;
  logic [8:0] rise;

  // Reset high: a pin already high at release must not look like a rising edge
  genvar gi;
  generate
    for (gi = 0; gi < 9; gi++) begin : g_pin
      always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
          sync1[gi] <= 1'b1;
          sync2[gi] <= 1'b1;
          sync3[gi] <= 1'b1;
        end else begin
          sync1[gi] <= pin_i[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
        end
      end
      assign rise[gi] = sync2[gi] && !sync3[gi];
    end
  endgenerate

  // ==========================================================
  // Clock-select field decode; code 00 means the ADC pin on some paths
  function automatic acs_pkg::acs_src_t map_sel(input logic [1:0] f,
                                                 input logic      adc_low);
    acs_pkg::acs_src_t s;
    s = acs_pkg::SRC_MAIN;
    unique case (f)
      2'h0: s = adc_low ? acs_pkg::SRC_ADCP : acs_pkg::SRC_MAIN;
      2'h1: s = acs_pkg::SRC_PLL_A;
      2'h2: s = acs_pkg::SRC_PLL_B;
      2'h3: s = acs_pkg::SRC_MAIN;
    endcase
    return s;
  endfunction

  // ==========================================================
  // Automatic clock choices
  logic              dac1_spdif;
  logic              tx_thru;
  acs_pkg::acs_src_t next_dac1_source_field;
  acs_pkg::acs_src_t next_tx_src;

  assign dac1_spdif = dac1_route == `ACS_RT_SPDIF;
  assign tx_thru    = tx_route == `ACS_RT_SPDIF;

  // With the bit 8 mode set the PLLs are taken by the receiver, so the
  // field choice is kept rather than forcing PLL A
  always_comb begin
    next_dac1_source_field = map_sel(clk_sel[`ACS_F_DACSEL], 1'b0);
    if (!manual && dac1_spdif && !rx2dac) begin
      next_dac1_source_field = acs_pkg::SRC_PLL_A;
    end
  end

  always_comb begin
    next_tx_src = map_sel(clk_sel[`ACS_F_TXSEL], 1'b1);
    if (!manual && tx_thru) begin
      next_tx_src = acs_pkg::SRC_PLL_A;
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      dac1_source_field_o      <= acs_pkg::SRC_MAIN;
      adc_src_o      <= acs_pkg::SRC_ADCP;
      spdif_tx_src_o <= acs_pkg::SRC_PLL_A;
      spdif_rx_src_o <= acs_pkg::SRC_PLL_A;
      prx_gen_src_o  <= acs_pkg::SRC_MAIN;
      prx_gen_en_o   <= 1'b0;
    end else begin
      dac1_source_field_o      <= next_dac1_source_field;
      adc_src_o      <= map_sel(clk_sel[`ACS_F_ADCSEL], 1'b1);
      spdif_tx_src_o <= next_tx_src;
      spdif_rx_src_o <= acs_pkg::SRC_PLL_A;
      prx_gen_src_o  <= map_sel(prx_ms[`ACS_F_PRXSEL], 1'b0);
      prx_gen_en_o   <= primary_rx_master_i;
    end
  end

  // ==========================================================
  // DAC power and DAC 2-4 routing
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      dac234_power_down_o   <= 1'b0;
      dac234_from_primary_o <= 1'b1;
    end else begin
      dac234_power_down_o   <= dac1_spdif && !rx2dac;
      dac234_from_primary_o <= !dac1_spdif || rx2dac;
    end
  end

  // ==========================================================
  // Rate reference selection
  acs_pkg::acs_ref_t ref_sel [3];
  acs_pkg::acs_src_t clk_src [3];

  always_comb begin
    unique case (dac1_route)
      `ACS_RT_SEC:   ref_sel[0] = acs_pkg::REF_SEC;
      `ACS_RT_SPDIF: ref_sel[0] = rx2dac ? acs_pkg::REF_PRX
                                         : acs_pkg::REF_SUB;
      default:       ref_sel[0] = acs_pkg::REF_PRX;
    endcase
  end

  always_comb begin
    if (ptx_route == `ACS_RT_ADC) begin
      ref_sel[1] = acs_pkg::REF_PTX;
    end else if (stx_route == `ACS_RT_ADC) begin
      ref_sel[1] = acs_pkg::REF_SEC;
    end else begin
      ref_sel[1] = acs_pkg::REF_FIELD;
    end
  end

  always_comb begin
    unique case (tx_route)
      `ACS_RT_SPDIF: ref_sel[2] = acs_pkg::REF_SUB;
      `ACS_RT_SEC:   ref_sel[2] = acs_pkg::REF_SECRX;
      `ACS_RT_PRI:   ref_sel[2] = acs_pkg::REF_PRX;
      default:       ref_sel[2] = (ptx_route == `ACS_RT_ADC)
                                  ? acs_pkg::REF_PTX
                                  : acs_pkg::REF_FIELD;
    endcase
  end

  assign clk_src[0] = next_dac1_source_field;
  assign clk_src[1] = map_sel(clk_sel[`ACS_F_ADCSEL], 1'b1);
  assign clk_src[2] = next_tx_src;

  // ==========================================================
  // Ratio meters, one per path; the meter counts edges of the
  // clock actually applied, so its result follows the auto choice
  acs_pkg::acs_ratio_t meas [3];
  acs_pkg::acs_ratio_t next_ratio [3];

  generate
    for (gi = 0; gi < 3; gi++) begin : g_path
      logic [3:0] frame_idx;
      assign frame_idx = {1'b0, ref_sel[gi]} + 4'h4;
      acs_ratio_meter u_meter (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .tick_i     (rise[clk_src[gi]]),
        .frame_i    (ref_sel[gi] != acs_pkg::REF_FIELD &&
                     rise[frame_idx]),
        .ratio_o    (meas[gi])
      );
      assign next_ratio[gi] = (ref_sel[gi] == acs_pkg::REF_FIELD)
                              ? acs_pkg::acs_ratio_t'(adc_field)
                              : meas[gi];
    end
  endgenerate

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      dac_ratio_o <= acs_pkg::R256;
      adc_ratio_o <= acs_pkg::R256;
      tx_ratio_o  <= acs_pkg::R256;
    end else begin
      dac_ratio_o <= next_ratio[0];
      adc_ratio_o <= next_ratio[1];
      tx_ratio_o  <= next_ratio[2];
    end
  end

  // ==========================================================
  // Checks
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  dac_field_b_a: assert property (
    manual && clk_sel[1:0] == 2'h2 |=> dac1_source_field_o == acs_pkg::SRC_PLL_B)
    else $error("DAC clock does not follow its field");

  dac_auto_pll_a: assert property (
    !manual && dac1_route == 2'h0 && !rx2dac |=> dac1_source_field_o == acs_pkg::SRC_PLL_A)
    else $error("DAC not forced onto PLL A");

  dac_power_mode_a: assert property (
    dac1_route == 2'h0 |=> dac234_power_down_o == !$past(rx2dac))
    else $error("DAC 2-4 power does not follow mode bit");

  adc_pin_sel_a: assert property (
    clk_sel[3:2] == 2'h0 |=> adc_src_o == acs_pkg::SRC_ADCP)
    else $error("ADC code 00 not the ADC pin");

  adc_field_ratio_a: assert property (
    ptx_route != 2'h1 && stx_route != 2'h1 |=> adc_ratio_o == $past(adc_field))
    else $error("ADC ratio not taken from field");

  rx_pll_a_a: assert property (
    ##1 spdif_rx_src_o == acs_pkg::SRC_PLL_A)
    else $error("Receiver clock left PLL A");

  tx_thru_pll_a: assert property (
    !manual && tx_route == 2'h0 |=> spdif_tx_src_o == acs_pkg::SRC_PLL_A)
    else $error("Transmitter not forced onto PLL A");

  tx_manual_sel_a: assert property (
    manual && clk_sel[5:4] == 2'h0 |=> spdif_tx_src_o == acs_pkg::SRC_ADCP)
    else $error("Manual mode did not disable auto choice");

  readback_a: assert property (
    wr_i && addr_i == 7'h08 ##1 addr_i == 7'h08 |=> rdata_o == $past(wdata_i, 2))
    else $error("Clock select readback differs from write");

  reset_vals_a: assert property (
    $fell(reset_i) |-> clk_sel == 9'h010 && adc_ctl == 9'h040 && dac1_src == 9'h180)
    else $error("Fields not at defaults after reset");

endmodule

// File: rtl/acs_regs.svh
// Register offsets, field positions, reset values and ratio thresholds
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH

// ==========================================================
// Register offsets (control port addresses)
`define ACS_A_CLKSEL   7'h08
`define ACS_A_PRXMS    7'h09
`define ACS_A_DAC1SRC  7'h0C
`define ACS_A_PTXSRC   7'h0D
`define ACS_A_STXSRC   7'h0E
`define ACS_A_DACMODE  7'h0F
`define ACS_A_ADCCTL   7'h1D
`define ACS_A_SPTXSRC  7'h1E

// ==========================================================
// Field positions
`define ACS_F_DACSEL   1:0
`define ACS_F_ADCSEL   3:2
`define ACS_F_TXSEL    5:4
`define ACS_B_MANUAL   6
`define ACS_F_PRXSEL   7:6
`define ACS_F_ROUTE    8:7
`define ACS_B_RX2DAC   8
`define ACS_F_ADC_RATIO_FIELD  7:5
`define ACS_F_TXDATA   1:0

// ==========================================================
// Reset values
`define ACS_RST_CLKSEL  9'h010
`define ACS_RST_PRXMS   9'h000
`define ACS_RST_DAC1SRC 9'h180
`define ACS_RST_PTXSRC  9'h080
`define ACS_RST_STXSRC  9'h000
`define ACS_RST_DACMODE 9'h000
`define ACS_RST_ADCCTL  9'h040
`define ACS_RST_SPTXSRC 9'h000

// ==========================================================
// Routing codes
`define ACS_RT_SPDIF   2'h0
`define ACS_RT_ADC     2'h1
`define ACS_RT_SEC     2'h2
`define ACS_RT_PRI     2'h3

// ==========================================================
// Ratio meter: midpoints between neighbouring master clock ratios
`define ACS_TH_192     12'h0A0
`define ACS_TH_256     12'h0E0
`define ACS_TH_384     12'h140
`define ACS_TH_512     12'h1C0
`define ACS_TH_768     12'h280
`define ACS_TH_1152    12'h3C0
`define ACS_CNT_MAX    12'hFFF

`endif

// File: rtl/acs_pkg.sv
// Types shared by the audio clock select block
package acs_pkg;

  // ==========================================================
  // Clock sources; code equals the sampled-pin index
  typedef enum logic [1:0] {
    SRC_MAIN  = 2'h0,
    SRC_ADCP  = 2'h1,
    SRC_PLL_A = 2'h2,
    SRC_PLL_B = 2'h3
  } acs_src_t;

  // ==========================================================
  // Rate references; code plus four is the sampled-pin index, except REF_FIELD, which has no pin
  typedef enum logic [2:0] {
    REF_PRX   = 3'h0,
    REF_PTX   = 3'h1,
    REF_SEC   = 3'h2,
    REF_SECRX = 3'h3,
    REF_SUB   = 3'h4,
    REF_FIELD = 3'h5
  } acs_ref_t;

  // ==========================================================
  // Clock-to-sample ratios
  typedef enum logic [2:0] {
    R128  = 3'h0,
    R192  = 3'h1,
    R256  = 3'h2,
    R384  = 3'h3,
    R512  = 3'h4,
    R768  = 3'h5,
    R1152 = 3'h6
  } acs_ratio_t;

endpackage

// File: rtl/acs_ratio_meter.sv
// Counts master clock edges per frame and quantises to a ratio code
`timescale 1ns/100ps
`include "acs_regs.svh"

module acs_ratio_meter (
  // Clock and reset
  input  wire logic               core_clk_i,
  input  wire logic               reset_i,
  // Edge pulses
  input  wire logic               tick_i,
  input  wire logic               frame_i,
  // Result
  output acs_pkg::acs_ratio_t     ratio_o
);

  logic [11:0] count;
  logic        armed;

  // ==========================================================
  // Edge counter, saturating so a stopped frame clock holds
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      count <= 12'h000;
    end else if (frame_i) begin
      count <= tick_i ? 12'h001 : 12'h000;
    end else if (tick_i && count != `ACS_CNT_MAX) begin
      count <= count + 12'h001;
    end
  end

  // ==========================================================
  // First frame edge after reset only starts the count; the span
  // before it is not a whole frame and would give a false ratio
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      armed <= 1'b0;
    end else if (frame_i) begin
      armed <= 1'b1;
    end
  end

  // ==========================================================
  // Quantise at each frame edge after the first
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ratio_o <= acs_pkg::R256;
    end else if (frame_i && armed) begin
      if (count < `ACS_TH_192) ratio_o <= acs_pkg::R128;
      else if (count < `ACS_TH_256) ratio_o <= acs_pkg::R192;
      else if (count < `ACS_TH_384) ratio_o <= acs_pkg::R256;
      else if (count < `ACS_TH_512) ratio_o <= acs_pkg::R384;
      else if (count < `ACS_TH_768) ratio_o <= acs_pkg::R512;
      else if (count < `ACS_TH_1152) ratio_o <= acs_pkg::R768;
      else ratio_o <= acs_pkg::R1152;
    end
  end

endmodule

// File: tb/acs_clk_partner.sv
// Behavioural model of the external master clock sources and frame clock hosts
`timescale 1ns/100ps

module acs_clk_partner (
  // Clock and frame pins
  output logic [8:0] pin_o
);
  // ==========================================================
  // Master clocks
  // One 25 MHz standard-rate source feeds all four master pins
  // 25 MHz is well under half the 100 MHz sampler rate, so the sampler still counts it faithfully
  logic        mclk = 1'b0;
  int unsigned cnt  = 0;

  initial begin
    forever #20 mclk = ~mclk;
  end

  // ==========================================================
  // Frame clocks
  // Slave mode: every frame clock comes from outside, divided from the master
  // Dividing from one source keeps S/PDIF and primary rates locked
  always @(posedge mclk) begin
    cnt <= (cnt + 1) % 1536;
  end

  assign pin_o[3:0] = {4{mclk}};
  assign pin_o[4]   = (cnt % 256) < 128;
  assign pin_o[5]   = (cnt % 512) < 256;
  assign pin_o[6]   = (cnt % 384) < 192;
  assign pin_o[7]   = (cnt % 192) < 96;
  assign pin_o[8]   = (cnt % 128) < 64;
endmodule

// File: tb/testbench.sv
// Self-checking testbench for the audio clock select block
`timescale 1ns/100ps

module testbench;
  // ==========================================================
  // Design signals
  logic                core_clk_i;
  logic                reset_i;
  logic                wr_i;
  logic [6:0]          addr_i;
  logic [8:0]          wdata_i;
  logic [8:0]          rdata_o;
  logic [8:0]          pin_i;
  logic                primary_rx_master_i;
  acs_pkg::acs_src_t   dac1_source_field_o, adc_src_o, spdif_tx_src_o, spdif_rx_src_o, prx_gen_src_o;
  logic                prx_gen_en_o;
  logic                dac234_power_down_o;
  logic                dac234_from_primary_o;
  acs_pkg::acs_ratio_t dac_ratio_o, adc_ratio_o, tx_ratio_o;
  int                  n_fail;
  int                  comparisons;
  int                  k;

  // ==========================================================
  // Expected tables
  logic [6:0]          ra [9] = '{7'h08, 7'h09, 7'h0C, 7'h0D, 7'h0E, 7'h0F, 7'h1D, 7'h1E, 7'h10};
  logic [8:0]          rv [9] = '{9'h010, 9'h000, 9'h180, 9'h080, 9'h000, 9'h000, 9'h040,
                                  9'h000, 9'h000};
  acs_pkg::acs_src_t   dmap [4] = '{acs_pkg::SRC_MAIN, acs_pkg::SRC_PLL_A, acs_pkg::SRC_PLL_B,
                                    acs_pkg::SRC_MAIN};
  acs_pkg::acs_src_t   amap [4] = '{acs_pkg::SRC_ADCP, acs_pkg::SRC_PLL_A, acs_pkg::SRC_PLL_B,
                                    acs_pkg::SRC_MAIN};

  acs_clk_partner partner_u (
    .pin_o(pin_i)
  );

  acs_clock_select dut_u (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .wr_i(wr_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .rdata_o(rdata_o), .pin_i(pin_i),
    .primary_rx_master_i(primary_rx_master_i), .dac1_source_field_o(dac1_source_field_o),
    .adc_src_o(adc_src_o), .spdif_tx_src_o(spdif_tx_src_o),
    .spdif_rx_src_o(spdif_rx_src_o), .prx_gen_src_o(prx_gen_src_o),
    .prx_gen_en_o(prx_gen_en_o), .dac234_power_down_o(dac234_power_down_o),
    .dac234_from_primary_o(dac234_from_primary_o), .dac_ratio_o(dac_ratio_o),
    .adc_ratio_o(adc_ratio_o), .tx_ratio_o(tx_ratio_o)
  );

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  // ==========================================================
  // Tasks
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [6:0] a, input logic [8:0] d);
    @(posedge core_clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge core_clk_i);
    wr_i    <= 1'b0;
  endtask

  task automatic rdchk(input logic [6:0] a, input logic [8:0] exp);
    @(posedge core_clk_i);
    addr_i <= a;
    repeat (2) @(posedge core_clk_i);
    #1;
    chk(rdata_o, exp);
  endtask

  // Derived outputs follow the register one edge later; three edges is margin
  task automatic settle();
    repeat (3) @(posedge core_clk_i);
    #1;
  endtask

  // Polls a ratio for up to 8000 cycles: nearly four full frames of the slowest reference
  task automatic wait_ratio(input int which, input acs_pkg::acs_ratio_t exp);
    acs_pkg::acs_ratio_t seen;
    int i;
    seen = acs_pkg::R128;
    for (i = 0; i < 8000; i++) begin
      @(posedge core_clk_i);
      #1;
      seen = (which == 0) ? dac_ratio_o : (which == 1) ? adc_ratio_o : tx_ratio_o;
      if (seen === exp) break;
    end
    chk(seen, exp);
    if (seen !== exp) summarize();
  endtask

  task automatic do_reset();
    @(posedge core_clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    reset_i <= 1'b0;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    n_fail = 0;
    comparisons = 0;
    reset_i = 1'b1;
    wr_i = 1'b0;
    addr_i = 7'h00;
    wdata_i = 9'h000;
    primary_rx_master_i = 1'b0;
    repeat (2) @(posedge core_clk_i);
    reset_i <= 1'b0;
    for (k = 0; k < 9; k++) rdchk(ra[k], rv[k]);
    settle();
    chk(dac1_source_field_o, acs_pkg::SRC_MAIN);
    chk(adc_src_o, acs_pkg::SRC_ADCP);
    chk(spdif_tx_src_o, acs_pkg::SRC_PLL_A);
    chk(spdif_rx_src_o, acs_pkg::SRC_PLL_A);
    chk(prx_gen_src_o, acs_pkg::SRC_MAIN);
    chk(prx_gen_en_o, 1'b0);
    chk({dac234_power_down_o, dac234_from_primary_o}, 2'h1);
    wait_ratio(0, acs_pkg::R256);
    wait_ratio(1, acs_pkg::R512);
    wait_ratio(2, acs_pkg::R128);
    // Clock fields; S/PDIF receiver taken as powered down while PLL codes are used
    for (k = 0; k < 4; k++) begin
      wr(7'h08, 9'(k));
      settle();
      chk(dac1_source_field_o, dmap[k]);
      wr(7'h08, 9'(k << 2));
      settle();
      chk(adc_src_o, amap[k]);
      wr(7'h09, 9'(k << 6));
      rdchk(7'h09, 9'(k << 6));
      chk(prx_gen_src_o, dmap[k]);
    end
    @(posedge core_clk_i);
    primary_rx_master_i <= 1'b1;
    settle();
    chk(prx_gen_en_o, 1'b1);
    wr(7'h1E, 9'h003);
    for (k = 0; k < 4; k++) begin
      wr(7'h08, 9'(k << 4));
      settle();
      chk(spdif_tx_src_o, amap[k]);
    end
    // Transmitter references per data route
    wait_ratio(2, acs_pkg::R256);
    wr(7'h1E, 9'h002);
    wait_ratio(2, acs_pkg::R192);
    wr(7'h1E, 9'h001);
    wait_ratio(2, acs_pkg::R512);
    wr(7'h0D, 9'h100);
    wait_ratio(2, acs_pkg::R256);
    wait_ratio(1, acs_pkg::R256);
    for (k = 0; k < 6; k++) begin
      wr(7'h1D, 9'(k << 5));
      settle();
      chk(adc_ratio_o, 9'(k));
      chk(tx_ratio_o, 9'(k));
    end
    wr(7'h0E, 9'h080);
    wait_ratio(1, acs_pkg::R384);
    wr(7'h0C, 9'h100);
    wait_ratio(0, acs_pkg::R384);
    // DAC1 on received S/PDIF data: forced clocks, subframe reference
    wr(7'h1E, 9'h000);
    wr(7'h08, 9'h032);
    wr(7'h0C, 9'h000);
    settle();
    chk(dac1_source_field_o, acs_pkg::SRC_PLL_A);
    chk(spdif_tx_src_o, acs_pkg::SRC_PLL_A);
    chk({dac234_power_down_o, dac234_from_primary_o}, 2'h2);
    rdchk(7'h08, 9'h032);
    wait_ratio(0, acs_pkg::R128);
    wr(7'h0F, 9'h100);
    settle();
    chk({dac234_power_down_o, dac234_from_primary_o}, 2'h1);
    chk(dac1_source_field_o, acs_pkg::SRC_PLL_B);
    wait_ratio(0, acs_pkg::R256);
    // Manual selection: fields apply as written
    wr(7'h0F, 9'h000);
    wr(7'h08, 9'h072);
    settle();
    chk(dac1_source_field_o, acs_pkg::SRC_PLL_B);
    chk(spdif_tx_src_o, acs_pkg::SRC_MAIN);
    chk(dac234_power_down_o, 1'b1);
    chk(spdif_rx_src_o, acs_pkg::SRC_PLL_A);
    rdchk(7'h08, 9'h072);
    wait_ratio(0, acs_pkg::R128);
    // Manual with code 00: no PLL A force on either path
    wr(7'h08, 9'h040);
    settle();
    chk(spdif_tx_src_o, acs_pkg::SRC_ADCP);
    chk(dac1_source_field_o, acs_pkg::SRC_MAIN);
    // DAC1 back on primary data: primary rx frame reference
    wr(7'h0C, 9'h180);
    wait_ratio(0, acs_pkg::R256);
    // Second reset in mid-run
    do_reset();
    for (k = 0; k < 9; k++) rdchk(ra[k], rv[k]);
    settle();
    chk(dac1_source_field_o, acs_pkg::SRC_MAIN);
    summarize();
  end
endmodule
